// ===== src/vpm_dev.sv
// multiply-accumulate block end: input, control, systolic and output banks
// assumes controls arrive from logic on the same clock
//
// Contract
// - complex products at 18x18, 18x25, 27x27
// - 18x18 complex: imaginary block, then real
// - 18x25 complex: three blocks with pre-adder
// - 27x27 complex: four blocks, two per part
// - fourth block flips sign for real part
// - adder-sum block counts per configuration
// - 18-bit adder sum gives 37-bit result
// - 16-bit adder sum, zero pad, 33 bits
// - sum of squares: pre-adders may subtract
// - pre-adder result feeds both multiplier operands
// - 18x18 product plus 36-bit addend
// - addend halves: low, then high input
// - systolic fir 18/27, three operand sources
// - 18-bit fir: dual 44-bit adders
// - 27-bit fir: 64-bit chain accumulator
// - fourteen dynamic controls, static or toggling
// - cascade operands to adjacent block
// - add/subtract select between two products
// - coefficient selects plus data msbs
// - three clocks, three enables, two clears
// - sign flip, preload, accumulate controls
// - accumulator function decode of three controls
// - 64-bit output bank, bypassable, zero
`timescale 1ns/1ps
module vpm_dev import vpm_pkg::*; (
  input wire logic CLK,
  input wire logic SRST,
  vpm_if.dev       BLK
);

  // qualified ticks of the three clock groups
  logic [2:0]        tick;
  // input bank
  logic [26:0]       ax_q;
  logic [26:0]       ay_q;
  logic [17:0]       bx_q;
  logic [17:0]       by_q;
  // control bank
  logic              sf_q;
  logic              pl_q;
  logic              sh_q;
  logic              as_q;
  logic              csa_q;
  logic              csb_q;
  // systolic bank for the upper multiplier
  logic [26:0]       axs_q;
  logic [26:0]       ays_q;
  // output bank and delayed chain
  logic [63:0]       out_q;
  logic [63:0]       chain_q;
  // datapath
  logic              sys_mode;
  logic [26:0]       ax_u;
  logic [26:0]       ay_u;
  logic [2:0]        idx_a;
  logic [2:0]        idx_b;
  logic signed [26:0] ay27;
  logic signed [17:0] b18;
  logic signed [17:0] d18;
  logic signed [18:0] pre_u;
  logic signed [18:0] pre_l;
  logic signed [26:0] pre27;
  logic signed [53:0] m27;
  logic signed [35:0] mu;
  logic signed [35:0] ml;
  logic signed [32:0] m16;
  logic signed [37:0] sq_u;
  logic signed [37:0] sq_l;
  logic signed [44:0] mpre;
  logic signed [63:0] prod;
  logic signed [63:0] term;
  logic [63:0]       base;
  logic [63:0]       sum;
  logic [63:0]       acc_d;

  // a group register moves only on its clock tick with its enable
  assign tick = {BLK.block_clock_2 & BLK.clock_enable_2,
                 BLK.block_clock_1 & BLK.clock_enable_1,
                 BLK.block_clock_0 & BLK.clock_enable_0};

  // input bank on group 0, cleared by clear 0
  always_ff @(posedge CLK or posedge BLK.async_clear_0) begin
    if (BLK.async_clear_0) begin
      ax_q <= VPM_RST_OP;
      ay_q <= VPM_RST_OP;
      bx_q <= VPM_RST_OP[17:0];
      by_q <= VPM_RST_OP[17:0];
    end else if (SRST) begin
      ax_q <= VPM_RST_OP;
      ay_q <= VPM_RST_OP;
      bx_q <= VPM_RST_OP[17:0];
      by_q <= VPM_RST_OP[17:0];
    end else if (tick[0]) begin
      // operand a may come down the cascade
      ax_q <= BLK.casc_sel ? BLK.cascade_in : BLK.op_ax;
      ay_q <= BLK.op_ay;
      bx_q <= BLK.op_bx;
      by_q <= BLK.op_by;
    end
  end

  // control bank on group 2, cleared by clear 0
  always_ff @(posedge CLK or posedge BLK.async_clear_0) begin
    if (BLK.async_clear_0) begin
      {sf_q, pl_q, sh_q, as_q, csa_q, csb_q} <= 6'h00;
    end else if (SRST) begin
      {sf_q, pl_q, sh_q, as_q, csa_q, csb_q} <= 6'h00;
    end else if (tick[2]) begin
      // controls may change every tick
      sf_q  <= BLK.sign_flip_ctl;
      pl_q  <= BLK.preset_load_ctl;
      sh_q  <= BLK.sum_hold_ctl;
      as_q  <= BLK.addsub_ctl;
      csa_q <= BLK.coef_mux_sel_a;
      csb_q <= BLK.coef_mux_sel_b;
    end
  end

  // systolic and output banks on group 1, cleared by clear 1
  always_ff @(posedge CLK or posedge BLK.async_clear_1) begin
    if (BLK.async_clear_1) begin
      axs_q   <= VPM_RST_OP;
      ays_q   <= VPM_RST_OP;
      out_q   <= VPM_RST_ACC;
      chain_q <= VPM_RST_ACC;
    end else if (SRST) begin
      axs_q   <= VPM_RST_OP;
      ays_q   <= VPM_RST_OP;
      out_q   <= VPM_RST_ACC;
      chain_q <= VPM_RST_ACC;
    end else if (tick[1]) begin
      axs_q   <= ax_q;
      ays_q   <= ay_q;
      out_q   <= acc_d;
      // chain leaves one stage late in systolic modes
      chain_q <= sys_mode ? out_q : acc_d;
    end
  end

  // operand selection and products
  always_comb begin
    sys_mode = (BLK.mode == VPM_SYS18) || (BLK.mode == VPM_SYS27);
    // upper multiplier reads the systolic bank in fir modes
    ax_u  = sys_mode ? axs_q : ax_q;
    ay_u  = sys_mode ? ays_q : ay_q;
    // coefficient index: select input and two data msbs
    idx_a = {csa_q, ay_u[17], ax_u[17]};
    idx_b = {csb_q, by_q[17], bx_q[17]};
    ay27  = BLK.coef_en ? VPM_COEF[idx_a] : ay_u;
    b18   = BLK.coef_en ? VPM_COEF[idx_a][17:0] : ay_u[17:0];
    d18   = BLK.coef_en ? VPM_COEF[idx_b][17:0] : by_q;
    // 18-bit pre-adders, b and d negated on subtract
    pre_u = BLK.preadd_sub ? $signed(ax_u[17:0]) - $signed(ay_u[17:0])
                           : $signed(ax_u[17:0]) + $signed(ay_u[17:0]);
    pre_l = BLK.preadd_sub ? $signed(bx_q) - $signed(by_q)
                           : $signed(bx_q) + $signed(by_q);
    // 26-bit pre-adder for 27-bit work
    pre27 = BLK.preadd_sub ? $signed(ay_u[25:0]) - $signed(by_q)
                           : $signed(ay_u[25:0]) + $signed(by_q);
    m27   = $signed(ax_u) * ay27;
    mu    = $signed(ax_u[17:0]) * b18;
    ml    = $signed(bx_q) * d18;
    // each pre-adder result squared on both operands
    sq_u  = pre_u * pre_u;
    sq_l  = pre_l * pre_l;
    // 16-bit sum held to 33 bits
    m16   = as_q ? 33'($signed(ax_u[15:0]) * $signed(b18[15:0]))
                 - 33'($signed(bx_q[15:0]) * $signed(d18[15:0]))
                 : 33'($signed(ax_u[15:0]) * $signed(b18[15:0]))
                 + 33'($signed(bx_q[15:0]) * $signed(d18[15:0]));
    mpre  = $signed(ax_u[17:0]) * pre27;
    unique case (BLK.mode)
      VPM_IND27:  prod = 64'(m27);
      VPM_SYS27:  prod = 64'(m27);
      VPM_ADD18:  prod = as_q ? 64'(mu) - 64'(ml)
                              : 64'(mu) + 64'(ml);
      VPM_SYS18:  prod = as_q ? 64'(mu) - 64'(ml)
                              : 64'(mu) + 64'(ml);
      VPM_ADD16:  prod = 64'(m16);
      VPM_SOS:    prod = 64'(sq_u) + 64'(sq_l);
      // addend: operand c low half, operand d high half
      VPM_PLUS36: prod = 64'(mu) + 64'($signed({by_q, bx_q}));
      VPM_PRE27:  prod = 64'(mpre);
    endcase
  end

  // accumulator and chain adder
  always_comb begin
    // product negated for decimation and for chained difference
    term = sf_q ? -prod : prod;
    unique case ({sf_q, pl_q, sh_q})
      VPM_ACC_LOAD: base = 64'h1 << BLK.preload_pos;
      VPM_ACC_ADD:  base = out_q;
      VPM_ACC_DEC:  base = out_q;
      default:      base = VPM_RST_ACC;
    endcase
    sum = base + term + (BLK.chain_en ? BLK.chain_in : VPM_RST_ACC);
    // 18-bit fir wraps in a 44-bit adder
    if (BLK.mode == VPM_SYS18) begin
      acc_d = {{20{sum[43]}}, sum[43:0]};
    end else if (BLK.mode == VPM_ADD18) begin
      acc_d = {{27{sum[36]}}, sum[36:0]};
    end else begin
      acc_d = sum;
    end
  end

  // bypass shows the adder output at once
  assign BLK.result      = BLK.out_bypass ? acc_d : out_q;
  assign BLK.chain_out   = chain_q;
  assign BLK.cascade_out = ax_q;

endmodule : vpm_dev

// ===== src/vpm_pkg.sv
// package for the variable precision multiply-accumulate block
// shared by the block end, the user-logic end and their interface
package vpm_pkg;

  // operating modes of one block
  typedef enum logic [2:0] {
    VPM_IND27,   // one 27x27 product
    VPM_ADD18,   // sum or difference of two 18x18 products
    VPM_ADD16,   // sum or difference of two 16x16 products
    VPM_SOS,     // sum of squares of two pre-adder results
    VPM_PLUS36,  // 18x18 product plus 36-bit addend
    VPM_PRE27,   // 18 x (26-bit pre-adder) product
    VPM_SYS18,   // 18-bit systolic fir stage
    VPM_SYS27    // 27-bit systolic fir stage
  } vpm_mode_t;

  // accumulator function codes {sign_flip, preset_load, sum_hold}
  localparam logic [2:0] VPM_ACC_ZERO = 3'h0;
  localparam logic [2:0] VPM_ACC_LOAD = 3'h2;
  localparam logic [2:0] VPM_ACC_ADD  = 3'h1;
  localparam logic [2:0] VPM_ACC_DEC  = 3'h5;

  // datapath widths
  localparam int VPM_W_ACC  = 64;
  localparam int VPM_W_SYS  = 44;
  localparam int VPM_W_ADD  = 37;
  localparam int VPM_W_ADD6 = 33;

  // reset value of the output bank and of every operand register
  localparam logic [63:0] VPM_RST_ACC = 64'h0;
  localparam logic [26:0] VPM_RST_OP  = 27'h0;

  // internal coefficient table, values arbitrary
  localparam logic [26:0] VPM_COEF [8] = '{
    27'h0000001, 27'h0000002, 27'h0000003, 27'h0000004,
    27'h7FFFFFF, 27'h7FFFFFE, 27'h0000010, 27'h0000100
  };

  // register word offsets of the user-logic end
  localparam logic [7:0] VPM_OFS_CFG   = 8'h00;
  localparam logic [7:0] VPM_OFS_CTRL  = 8'h04;
  localparam logic [7:0] VPM_OFS_STEP  = 8'h08;
  localparam logic [7:0] VPM_OFS_OPA   = 8'h0C;
  localparam logic [7:0] VPM_OFS_OPB   = 8'h10;
  localparam logic [7:0] VPM_OFS_OPC   = 8'h14;
  localparam logic [7:0] VPM_OFS_OPD   = 8'h18;
  localparam logic [7:0] VPM_OFS_CHLO  = 8'h1C;
  localparam logic [7:0] VPM_OFS_CHHI  = 8'h20;
  localparam logic [7:0] VPM_OFS_RESLO = 8'h24;
  localparam logic [7:0] VPM_OFS_RESHI = 8'h28;
  localparam logic [7:0] VPM_OFS_CASC  = 8'h2C;
  localparam logic [7:0] VPM_OFS_COUT  = 8'h30;

  // configuration word fields
  localparam int VPM_CFG_MODE = 0;   // bits 2:0
  localparam int VPM_CFG_PSUB = 4;
  localparam int VPM_CFG_COEF = 5;
  localparam int VPM_CFG_BYP  = 6;
  localparam int VPM_CFG_CHEN = 7;
  localparam int VPM_CFG_CASC = 8;
  localparam int VPM_CFG_PPOS = 9;   // bits 14:9

  // dynamic control word fields
  localparam int VPM_CTL_SF  = 0;
  localparam int VPM_CTL_PL  = 1;
  localparam int VPM_CTL_SH  = 2;
  localparam int VPM_CTL_AS  = 3;
  localparam int VPM_CTL_CSA = 4;
  localparam int VPM_CTL_CSB = 5;
  localparam int VPM_CTL_ENA = 6;    // bits 8:6
  localparam int VPM_CTL_CLR = 9;    // bits 10:9
  localparam int VPM_CTL_RUN = 11;   // bits 13:11

  // reset values of the user-logic registers
  localparam logic [31:0] VPM_RST_CFG  = 32'h0;
  localparam logic [31:0] VPM_RST_CTRL = 32'h0;

endpackage : vpm_pkg

// ===== src/vpm_if.sv
// interface joining the block end and the user-logic end
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface vpm_if import vpm_pkg::*; ();
  vpm_mode_t   mode;            // static operating mode
  logic        preadd_sub;      // pre-adder subtracts
  logic        coef_en;         // coefficient replaces multiplicand
  logic        out_bypass;      // output bank bypassed
  logic        chain_en;        // chain input added
  logic        casc_sel;        // operand a from cascade input
  logic [5:0]  preload_pos;     // one-hot preload bit position
  logic        sign_flip_ctl;   // sign_flip_ctl current product
  logic        preset_load_ctl; // preload accumulator
  logic        sum_hold_ctl;    // accumulate
  logic        addsub_ctl;      // subtract second product
  logic        coef_mux_sel_a;  // coefficient select, upper
  logic        coef_mux_sel_b;  // coefficient select, lower
  logic        block_clock_0;   // tick of clock group 0
  logic        block_clock_1;   // tick of clock group 1
  logic        block_clock_2;   // tick of clock group 2
  logic        clock_enable_0;  // enable of group 0
  logic        clock_enable_1;  // enable of group 1
  logic        clock_enable_2;  // enable of group 2
  logic        async_clear_0;   // clears input and control regs
  logic        async_clear_1;   // clears output regs
  logic [26:0] op_ax;           // operand a
  logic [26:0] op_ay;           // operand b
  logic [17:0] op_bx;           // operand c
  logic [17:0] op_by;           // operand d
  logic [26:0] cascade_in;      // operand from previous block
  logic [63:0] chain_in;        // chain from previous block
  logic [63:0] result;          // block result
  logic [63:0] chain_out;       // chain to next block
  logic [26:0] cascade_out;     // operand to next block

  // block end
  modport dev (
    input  mode, preadd_sub, coef_en, out_bypass, chain_en, casc_sel,
    input  preload_pos, sign_flip_ctl, preset_load_ctl, sum_hold_ctl,
    input  addsub_ctl, coef_mux_sel_a, coef_mux_sel_b,
    input  block_clock_0, block_clock_1, block_clock_2,
    input  clock_enable_0, clock_enable_1, clock_enable_2,
    input  async_clear_0, async_clear_1,
    input  op_ax, op_ay, op_bx, op_by, cascade_in, chain_in,
    output result, chain_out, cascade_out
  );

  // user-logic end
  modport usr (
    output mode, preadd_sub, coef_en, out_bypass, chain_en, casc_sel,
    output preload_pos, sign_flip_ctl, preset_load_ctl, sum_hold_ctl,
    output addsub_ctl, coef_mux_sel_a, coef_mux_sel_b,
    output block_clock_0, block_clock_1, block_clock_2,
    output clock_enable_0, clock_enable_1, clock_enable_2,
    output async_clear_0, async_clear_1,
    output op_ax, op_ay, op_bx, op_by, cascade_in, chain_in,
    input  result, chain_out, cascade_out
  );
endinterface : vpm_if

// ===== src/vpm_usr.sv
// user-logic end: apb slave registers that drive one block
// assumes an apb master on CLK; block joined through vpm_if
`timescale 1ns/1ps
module vpm_usr import vpm_pkg::*; (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  vpm_if.usr               BLK
);

  logic [31:0] cfg_q;    // configuration word
  logic [31:0] ctrl_q;   // dynamic control word
  logic [2:0]  step_q;   // one-shot group ticks
  logic [26:0] opa_q;    // operand a
  logic [26:0] opb_q;    // operand b
  logic [17:0] opc_q;    // operand c, low addend half
  logic [17:0] opd_q;    // operand d, high addend half
  logic [63:0] chain_q;  // chain input
  logic [26:0] casc_q;   // cascade input
  logic        wr_en;    // write takes effect
  logic        pad16;    // 16-bit mode pads operands
  logic [31:0] rd_data;  // read mux
  logic        rd_err;   // unmapped address

  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;
  assign pad16 = cfg_q[VPM_CFG_MODE +: 3] == VPM_ADD16;

  // one wait state, then answer
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PRDATA  <= (PSEL & PENABLE & ~PREADY & ~PWRITE) ? rd_data : 32'h0;
      PSLVERR <= PSEL & PENABLE & ~PREADY & rd_err;
    end
  end

  // register writes
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cfg_q   <= VPM_RST_CFG;
      ctrl_q  <= VPM_RST_CTRL;
      opa_q   <= VPM_RST_OP;
      opb_q   <= VPM_RST_OP;
      opc_q   <= VPM_RST_OP[17:0];
      opd_q   <= VPM_RST_OP[17:0];
      chain_q <= VPM_RST_ACC;
      casc_q  <= VPM_RST_OP;
    end else if (wr_en) begin
      unique case (PADDR)
        VPM_OFS_CFG:  cfg_q  <= PWDATA;
        VPM_OFS_CTRL: ctrl_q <= PWDATA;
        // unused high bits zeroed in 16-bit mode
        VPM_OFS_OPA:  opa_q <= pad16 ? {11'h0, PWDATA[15:0]} : PWDATA[26:0];
        VPM_OFS_OPB:  opb_q <= pad16 ? {11'h0, PWDATA[15:0]} : PWDATA[26:0];
        VPM_OFS_OPC:  opc_q <= pad16 ? {2'h0, PWDATA[15:0]} : PWDATA[17:0];
        VPM_OFS_OPD:  opd_q <= pad16 ? {2'h0, PWDATA[15:0]} : PWDATA[17:0];
        VPM_OFS_CHLO: chain_q[31:0]  <= PWDATA;
        VPM_OFS_CHHI: chain_q[63:32] <= PWDATA;
        VPM_OFS_CASC: casc_q <= PWDATA[26:0];
        default:      ;
      endcase
    end
  end

  // step pulses one tick per written group
  always_ff @(posedge CLK) begin
    if (SRST) begin
      step_q <= 3'h0;
    end else begin
      step_q <= (wr_en && PADDR == VPM_OFS_STEP) ? PWDATA[2:0] : 3'h0;
    end
  end

  // read mux
  always_comb begin
    rd_err = 1'b0;
    unique case (PADDR)
      VPM_OFS_CFG:   rd_data = cfg_q;
      VPM_OFS_CTRL:  rd_data = ctrl_q;
      VPM_OFS_STEP:  rd_data = 32'h0;
      VPM_OFS_OPA:   rd_data = {5'h0, opa_q};
      VPM_OFS_OPB:   rd_data = {5'h0, opb_q};
      VPM_OFS_OPC:   rd_data = {14'h0, opc_q};
      VPM_OFS_OPD:   rd_data = {14'h0, opd_q};
      VPM_OFS_CHLO:  rd_data = chain_q[31:0];
      VPM_OFS_CHHI:  rd_data = chain_q[63:32];
      VPM_OFS_RESLO: rd_data = BLK.result[31:0];
      VPM_OFS_RESHI: rd_data = BLK.result[63:32];
      VPM_OFS_CASC:  rd_data = {5'h0, casc_q};
      VPM_OFS_COUT:  rd_data = {5'h0, BLK.cascade_out};
      default: begin
        rd_data = 32'h0;
        rd_err  = 1'b1;
      end
    endcase
  end

  // drive the block from the registers
  assign BLK.mode            = vpm_mode_t'(cfg_q[VPM_CFG_MODE +: 3]);
  assign BLK.preadd_sub      = cfg_q[VPM_CFG_PSUB];
  assign BLK.coef_en         = cfg_q[VPM_CFG_COEF];
  assign BLK.out_bypass      = cfg_q[VPM_CFG_BYP];
  assign BLK.chain_en        = cfg_q[VPM_CFG_CHEN];
  assign BLK.casc_sel        = cfg_q[VPM_CFG_CASC];
  assign BLK.preload_pos     = cfg_q[VPM_CFG_PPOS +: 6];
  assign BLK.sign_flip_ctl   = ctrl_q[VPM_CTL_SF];
  assign BLK.preset_load_ctl = ctrl_q[VPM_CTL_PL];
  assign BLK.sum_hold_ctl    = ctrl_q[VPM_CTL_SH];
  assign BLK.addsub_ctl      = ctrl_q[VPM_CTL_AS];
  assign BLK.coef_mux_sel_a  = ctrl_q[VPM_CTL_CSA];
  assign BLK.coef_mux_sel_b  = ctrl_q[VPM_CTL_CSB];
  assign BLK.clock_enable_0  = ctrl_q[VPM_CTL_ENA];
  assign BLK.clock_enable_1  = ctrl_q[VPM_CTL_ENA + 1];
  assign BLK.clock_enable_2  = ctrl_q[VPM_CTL_ENA + 2];
  assign BLK.async_clear_0   = ctrl_q[VPM_CTL_CLR];
  assign BLK.async_clear_1   = ctrl_q[VPM_CTL_CLR + 1];
  // free-running groups tick every clock, others on step
  assign BLK.block_clock_0   = ctrl_q[VPM_CTL_RUN] | step_q[0];
  assign BLK.block_clock_1   = ctrl_q[VPM_CTL_RUN + 1] | step_q[1];
  assign BLK.block_clock_2   = ctrl_q[VPM_CTL_RUN + 2] | step_q[2];
  assign BLK.op_ax           = opa_q;
  assign BLK.op_ay           = opb_q;
  assign BLK.op_bx           = opc_q;
  assign BLK.op_by           = opd_q;
  assign BLK.cascade_in      = casc_q;
  assign BLK.chain_in        = chain_q;

endmodule : vpm_usr

// ===== dv/vpm_assertions.sv
// checker for the link between the block end and the user-logic end
// assumes one clock; takes the interface signals as plain inputs
`timescale 1ns/1ps
module vpm_assertions import vpm_pkg::*; (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire vpm_mode_t   mode,
  input wire logic        out_bypass,
  input wire logic        casc_sel,
  input wire logic        block_clock_0,
  input wire logic        block_clock_1,
  input wire logic        clock_enable_0,
  input wire logic        clock_enable_1,
  input wire logic        async_clear_0,
  input wire logic        async_clear_1,
  input wire logic [26:0] op_ax,
  input wire logic [63:0] result,
  input wire logic [63:0] chain_out,
  input wire logic [26:0] cascade_out
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // output bank reads zero right after reset
  a_reset_out_zero: assert property ($fell(SRST) |-> result == 64'h0)
    else $error("result not zero after reset");
  // output clear forces result and chain to zero without a tick
  a_out_clear_zero: assert property (async_clear_1 && !out_bypass |->
    result == 64'h0 && chain_out == 64'h0) else $error("output clear ignored");
  // input clear empties the operand bank, seen on the cascade output
  a_in_clear_zero: assert property (async_clear_0 |-> cascade_out == 27'h0)
    else $error("input clear ignored");
  // operand a goes on to the next block one tick later
  a_cascade_fwd: assert property (block_clock_0 && clock_enable_0 && !casc_sel
    |=> async_clear_0 || cascade_out == $past(op_ax)) else $error("cascade lost");
  // no enabled tick, operand bank holds
  a_cascade_hold: assert property (!(block_clock_0 && clock_enable_0)
    |=> async_clear_0 || $stable(cascade_out)) else $error("input bank moved");
  // no enabled tick, output bank holds
  a_out_hold: assert property (!(block_clock_1 && clock_enable_1) && !out_bypass
    |=> async_clear_1 || out_bypass || $stable(result)) else $error("output moved");
  // non-systolic chain output is the same sum as the output bank
  a_chain_match: assert property (block_clock_1 && clock_enable_1 &&
    !(mode inside {VPM_SYS18, VPM_SYS27}) |=> async_clear_1 || out_bypass ||
    chain_out == result) else $error("chain and result differ");
  // 18-bit adder sum stays a 37-bit signed value
  a_add18_width: assert property (block_clock_1 && clock_enable_1 &&
    mode == VPM_ADD18 |=> async_clear_1 || out_bypass ||
    result[63:36] == {28{result[36]}}) else $error("adder sum wider than 37 bits");
  // systolic chain output trails the output bank by one tick
  a_sys_chain_lag: assert property (block_clock_1 && clock_enable_1 && !out_bypass &&
    mode inside {VPM_SYS18, VPM_SYS27} |=> async_clear_1 || chain_out == $past(result))
    else $error("systolic chain not delayed");

  // main scenarios
  c_add18_tick: cover property (block_clock_1 && clock_enable_1 && mode == VPM_ADD18);
  c_plus36_tick: cover property (block_clock_1 && clock_enable_1 && mode == VPM_PLUS36);
  c_out_clear: cover property (async_clear_1);
  c_sys27_tick: cover property (block_clock_1 && clock_enable_1 && mode == VPM_SYS27);
endmodule : vpm_assertions

// ===== dv/vpm_bench.sv
// bench: apb master drives the user-logic end, which drives the block end
// assumes one 20 MHz clock and synchronous active-high reset
`timescale 1ns/1ps
module vpm_bench import vpm_pkg::*;;
  logic        CLK, SRST, PSEL, PENABLE, PWRITE; // apb and clock
  logic [7:0]  PADDR;                            // byte address
  logic [31:0] PWDATA, PRDATA, rdat, lo;         // data and captures
  logic        PREADY, PSLVERR, rerr;            // answer and capture
  int          fails, n_compared;                // counters
  // accumulator control codes and sums for operands 3,5,2,7
  logic [3:0]  tab_ctl [7] = '{4'h0, 4'h4, 4'h4, 4'h5, 4'h2, 4'h1, 4'h8};
  logic [63:0] tab_exp [7] = '{64'h1D, 64'h3A, 64'h57, 64'h3A, 64'h2D,
                               64'hFFFFFFFFFFFFFFE3, 64'h1};

  vpm_if bif ();
  vpm_usr u_vpm_usr (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .BLK(bif));
  vpm_dev u_vpm_dev (.CLK(CLK), .SRST(SRST), .BLK(bif));
  vpm_assertions u_vpm_assertions (.CLK(CLK), .SRST(SRST), .mode(bif.mode),
    .out_bypass(bif.out_bypass), .casc_sel(bif.casc_sel),
    .block_clock_0(bif.block_clock_0), .block_clock_1(bif.block_clock_1),
    .clock_enable_0(bif.clock_enable_0), .clock_enable_1(bif.clock_enable_1),
    .async_clear_0(bif.async_clear_0), .async_clear_1(bif.async_clear_1),
    .op_ax(bif.op_ax), .result(bif.result), .chain_out(bif.chain_out),
    .cascade_out(bif.cascade_out));

  // 50 ns clock
  always #25 CLK = ~CLK;

  // one apb transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask : apb

  // compare and count
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [63:0] exp);
    apb(1'b0, a, 32'h0);
    chk({32'h0, rdat}, exp);
  endtask : rd

  // 64-bit result as low word then high word
  task rd64(input logic [63:0] exp);
    apb(1'b0, VPM_OFS_RESLO, 32'h0);
    lo = rdat;
    apb(1'b0, VPM_OFS_RESHI, 32'h0);
    chk({rdat, lo}, exp);
  endtask : rd64

  // verdict, the single exit of the run
  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // watchdog well beyond the few hundred cycles of the tests
  initial begin
    repeat (5000) @(posedge CLK);
    fails++;
    test_done;
  end

  initial begin
    CLK = 0; SRST = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 8'h0; PWDATA = 32'h0;
    fails = 0; n_compared = 0;
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    rd(VPM_OFS_CTRL, 64'h0);
    rd64(64'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({63'h0, rerr}, 64'h1);
    // adder sum, preload at bit 4, all enables, ticks by step only
    wr(VPM_OFS_CFG, 32'h801);
    wr(VPM_OFS_CTRL, 32'h1C0);
    wr(VPM_OFS_OPA, 32'h3);
    wr(VPM_OFS_OPB, 32'h5);
    wr(VPM_OFS_OPC, 32'h2);
    wr(VPM_OFS_OPD, 32'h7);
    wr(VPM_OFS_STEP, 32'h1);
    rd(VPM_OFS_COUT, 64'h3);
    // every accumulator code, then subtract of the second product
    for (int i = 0; i < 7; i++) begin
      wr(VPM_OFS_CTRL, 32'h1C0 | {28'h0, tab_ctl[i]});
      wr(VPM_OFS_STEP, 32'h4);
      wr(VPM_OFS_STEP, 32'h2);
      rd64(tab_exp[i]);
    end
    // bypass shows the unregistered sum, bank still holds 1
    wr(VPM_OFS_CTRL, 32'h1C0);
    wr(VPM_OFS_STEP, 32'h4);
    wr(VPM_OFS_CFG, 32'h841);
    rd64(64'h1D);
    // 16-bit mode pads the upper operand bits
    wr(VPM_OFS_CFG, 32'h802);
    wr(VPM_OFS_OPA, 32'h30003);
    rd(VPM_OFS_OPA, 64'h3);
    wr(VPM_OFS_STEP, 32'h1);
    wr(VPM_OFS_STEP, 32'h2);
    rd64(64'h1D);
    // product plus addend made of c low and d high
    wr(VPM_OFS_CFG, 32'h804);
    wr(VPM_OFS_STEP, 32'h2);
    rd64(64'h1C0011);
    // clears act with no tick running
    wr(VPM_OFS_CTRL, 32'h5C0);
    rd64(64'h0);
    wr(VPM_OFS_CTRL, 32'h3C0);
    rd(VPM_OFS_COUT, 64'h0);
    // reset in mid-run returns the registers to zero
    @(posedge CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    rd(VPM_OFS_CFG, 64'h0);
    // sum of squares with subtracting pre-adders, then a plain 27x27
    wr(VPM_OFS_CTRL, 32'h1C0);
    wr(VPM_OFS_OPA, 32'h9);
    wr(VPM_OFS_OPB, 32'h4);
    wr(VPM_OFS_OPC, 32'h6);
    wr(VPM_OFS_OPD, 32'h1);
    wr(VPM_OFS_CFG, 32'h13);
    wr(VPM_OFS_STEP, 32'h1);
    wr(VPM_OFS_STEP, 32'h2);
    rd64(64'h32);
    wr(VPM_OFS_CFG, 32'h0);
    wr(VPM_OFS_STEP, 32'h2);
    rd64(64'h24);
    // 27-bit systolic: product lags the input bank by one group-1 tick
    wr(VPM_OFS_CFG, 32'h7);
    wr(VPM_OFS_OPA, 32'h2);
    wr(VPM_OFS_STEP, 32'h1);
    wr(VPM_OFS_STEP, 32'h2);
    rd64(64'h24);
    wr(VPM_OFS_STEP, 32'h2);
    rd64(64'h8);
    // 18-bit systolic with chain input at bit 43 wraps in 44 bits
    wr(VPM_OFS_CHHI, 32'h800);
    wr(VPM_OFS_CFG, 32'h86);
    wr(VPM_OFS_STEP, 32'h2);
    rd64(64'hFFFFF8000000000E);
    // operand a from the cascade input, then the 26-bit pre-adder product
    wr(VPM_OFS_CASC, 32'h15);
    wr(VPM_OFS_CFG, 32'h105);
    wr(VPM_OFS_STEP, 32'h1);
    rd(VPM_OFS_COUT, 64'h15);
    wr(VPM_OFS_STEP, 32'h2);
    rd64(64'h69);
    // coefficient table entry replaces operand b
    wr(VPM_OFS_CFG, 32'h120);
    wr(VPM_OFS_STEP, 32'h2);
    rd64(64'h15 * 64'(VPM_COEF[0]));
    test_done;
  end
endmodule : vpm_bench
